// ### gate_four_pkg.sv
// types shared by the gate-four select block
// assumes gate_four_regs.svh supplies the numeric constants
package gate_four_pkg;

    // one true/inverted pair per data input
    typedef struct packed {
        logic true_sel;
        logic inv_sel;
    } sel_pair_t;

    // bit 7 down to bit 0: input 4 pair down to input 1 pair
    typedef struct packed {
        sel_pair_t in4;
        sel_pair_t in3;
        sel_pair_t in2;
        sel_pair_t in1;
    } gate_sel_t;

    typedef struct packed {
        logic [3:0] cell_out;
    } cell_outs_t;

endpackage

// ### gate_four_regs.svh
// register offsets, field positions and reset values for the gate-four select block
// assumes a 32-bit apb bus with word-aligned registers
`ifndef GATE_FOUR_REGS_SVH
`define GATE_FOUR_REGS_SVH

`define GLS_OFFSET       12'h000
`define MIRROR_OFFSET    12'h004
`define DSEL1_OFFSET     12'h008
`define DSEL2_OFFSET     12'h00c
`define DSEL3_OFFSET     12'h010
`define DSEL4_OFFSET     12'h014
`define DSEL_WIDTH       5
`define GLS_RESET        8'h00
`define DSEL_RESET       5'h00
`define MIRROR_USED      4

`endif

// ### gate_four_sel.sv
// fourth gate input select, data source selects and cell output mirror
// assumes an apb master on pclk and cell outputs from logic on the same clock
//
// Behaviour
// - a set true bit gates the plain data input into gate four
// - a set negated bit gates the inverted data input into gate four
// - bit pairs hold inputs four down to one, true bit above negated
// - a cleared select bit leaves that term out of gate four
// - all eight select bits are read/write; only power-on reset touches them
// - mirror register bits three to zero copy cell outputs four to one
// - mirror bits seven to four read as zero
// - each data input is picked by a five-bit field in its own register
`timescale 1ns/1ns
`default_nettype none
`include "gate_four_regs.svh"

module gate_four_sel
    import gate_four_pkg::*;
#(
    parameter int NUM_SOURCES = 32
)
(
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // cell side
    input  wire logic [NUM_SOURCES-1:0] source_bus,
    input  wire cell_outs_t             cell_outputs,
    output logic      [3:0]             data_in_true,
    output logic      [3:0]             data_in_inverted,
    output logic                        fourth_gate_out
);

    // ****************************************
    // registers
    // ****************************************
    gate_sel_t                  gate_four_input_select;
    logic [`DSEL_WIDTH-1:0]     data_source_field [4];
    logic [3:0]                 mirror_sample;
    logic                       wr_en;
    logic                       rd_en;
    logic                       addr_ok;

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == `GLS_OFFSET) || (a == `MIRROR_OFFSET) || (a == `DSEL1_OFFSET) ||
                      (a == `DSEL2_OFFSET) || (a == `DSEL3_OFFSET) || (a == `DSEL4_OFFSET);
    endfunction

    // zero-wait slave: access phase completes in its first cycle
    assign pready  = 1'b1;
    assign addr_ok = addr_mapped(paddr);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gate_four_input_select <= `GLS_RESET;
        else if (wr_en && paddr == `GLS_OFFSET)
            gate_four_input_select <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
                data_source_field[i] <= `DSEL_RESET;
        end
        else if (wr_en)
        begin
            for (int i = 0; i < 4; i++)
                if (paddr == `DSEL1_OFFSET + 12'(4 * i))
                    data_source_field[i] <= pwdata[`DSEL_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mirror_sample <= 4'h0;
        else
            mirror_sample <= cell_outputs.cell_out;
    end

    // ****************************************
    // read data
    // ****************************************
    // read data registered in setup phase so it is steady in access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
        begin
            prdata <= 32'h0000_0000;
            if (paddr == `GLS_OFFSET)
                prdata[7:0] <= gate_four_input_select;
            else if (paddr == `MIRROR_OFFSET)
                prdata[`MIRROR_USED-1:0] <= mirror_sample;
            else
                for (int i = 0; i < 4; i++)
                    if (paddr == `DSEL1_OFFSET + 12'(4 * i))
                        prdata[`DSEL_WIDTH-1:0] <= data_source_field[i];
        end
    end

    // ****************************************
    // data inputs and gate four
    // ****************************************
    // registered mux keeps the gate output glitch free
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_in_true     <= 4'h0;
            data_in_inverted <= 4'hf;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                data_in_true[i]     <= source_bus[data_source_field[i]];
                data_in_inverted[i] <= ~source_bus[data_source_field[i]];
            end
        end
    end

    always_comb
    begin
        logic [3:0] t_sel;
        logic [3:0] n_sel;
        t_sel = 4'h0;
        n_sel = 4'h0;
        t_sel = {gate_four_input_select.in4.true_sel, gate_four_input_select.in3.true_sel,
                 gate_four_input_select.in2.true_sel, gate_four_input_select.in1.true_sel};
        n_sel = {gate_four_input_select.in4.inv_sel, gate_four_input_select.in3.inv_sel,
                 gate_four_input_select.in2.inv_sel, gate_four_input_select.in1.inv_sel};
        fourth_gate_out = |((data_in_true & t_sel) | (data_in_inverted & n_sel));
    end

endmodule
`default_nettype wire

// ### gate_four_sel_chk.sv
// port checker for gate_four_sel
// bound into every instance, sees its ports only
`timescale 1ns/1ns
`default_nettype none
`include "gate_four_regs.svh"
module gate_four_chk (
    input wire logic pclk, presetn, psel, penable, pwrite, pslverr, fourth_gate_out,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] data_in_true, data_in_inverted
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    wire logic rds = psel && !penable && !pwrite;
    wire logic gw = acc && pwrite && paddr == `GLS_OFFSET;
    wire logic bad = paddr > `DSEL4_OFFSET;
    a_inv_pair: assert property (data_in_inverted == ~data_in_true) else $error("inverse");
    a_gate_none: assert property (gw && pwdata[7:0] == 8'h00 |=> !fourth_gate_out) else $error("gate on");
    a_gate_all: assert property (gw && pwdata[7:0] == 8'hff |=> fourth_gate_out) else $error("gate off");
    a_err_unmap: assert property (acc && bad |-> pslverr) else $error("no error");
    a_err_idle: assert property (!acc |-> !pslverr) else $error("stray error");
    a_rd_unmap: assert property (rds && bad |=> prdata == 32'h0) else $error("read data");
    a_mirror_top: assert property (rds && paddr == `MIRROR_OFFSET |=> prdata[31:4] == 28'h0) else $error("high");
    a_sel_top: assert property (rds && paddr == `GLS_OFFSET |=> prdata[31:8] == 24'h0) else $error("high");
endmodule
bind gate_four_sel gate_four_chk u_chk (.*);
`default_nettype wire

// ### gate_four_sel_tb.sv
// bench: apb master plus cell-side stimulus
// no partner model, checker bound separately
`timescale 1ns/1ns
`default_nettype none
`include "gate_four_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("wrong value %0t compare", $time); end end
module gate_four_sel_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, gout;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, src = 0, seed = 32'h2d, q;
    logic [3:0] cells = 0;
    logic [7:0] gls;
    logic [4:0] dsel [4];
    int miscompares = 0, n_tests = 0;
    gate_four_sel u_gate_four_sel (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .source_bus(src), .cell_outputs(cells), .data_in_true(), .data_in_inverted(), .fourth_gate_out(gout));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic gexp();
        gexp = 0;
        for (int i = 0; i < 4; i++)
            gexp |= gls[2*i+1] & src[dsel[i]] | gls[2*i] & ~src[dsel[i]];
    endfunction
    task apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {q, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task final_report();
        if (miscompares == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
        forever #5 pclk = ~pclk;
    initial
    begin
        #50000;
        miscompares++;
        final_report();
    end
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 40; k++)
        begin
            // all terms, no terms, then random
            gls = k == 0 ? 8'hff : k == 1 ? 8'h00 : 8'(rnd());
            for (int i = 0; i < 4; i++)
            begin
                dsel[i] = 5'(rnd());
                apb(1'b1, `DSEL1_OFFSET + 12'(4 * i), {27'h0, dsel[i]});
            end
            apb(1'b1, `GLS_OFFSET, {24'h0, gls});
            src <= rnd();
            cells <= 4'(rnd());
            apb(k[0], 12'h020, rnd());
            `CHK(err, 1'b1)
            if (!k[0])
                `CHK(q, 32'h0)
            for (int i = 0; i < 4; i++)
            begin
                apb(1'b0, `DSEL1_OFFSET + 12'(4 * i), 32'h0);
                `CHK(q, {27'h0, dsel[i]})
            end
            apb(1'b1, `MIRROR_OFFSET, 32'hf);
            apb(1'b0, `GLS_OFFSET, 32'h0);
            `CHK(q, {24'h0, gls})
            `CHK(gout, gexp())
            apb(1'b0, `MIRROR_OFFSET, 32'h0);
            `CHK(q, {28'h0, cells})
        end
        final_report();
    end
endmodule
`default_nettype wire
